// ===== design/msu_pkg.sv
// ****************************************************************
// Shared constants of the motor start-up supervision stage
// ****************************************************************
package msu_pkg;

  // Clock rate and the millisecond time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequence times, in milliseconds (one count per millisecond tick)
  localparam logic [15:0] STOP_QUAL_MS = 16'h01f4;
  localparam logic [15:0] WINDOW_MS = 16'h00c8;

  // Limits as fractions num/den of the motor nominal current
  localparam logic [3:0] STOP_NUM = 4'h1;
  localparam logic [3:0] STOP_DEN = 4'ha;
  localparam logic [3:0] RUNLO_NUM = 4'h1;
  localparam logic [3:0] RUNLO_DEN = 4'h5;
  localparam logic [3:0] RUNHI_NUM = 4'h6;
  localparam logic [3:0] RUNHI_DEN = 4'h5;

  // Register word offsets on the Avalon-MM slave
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_NOMINAL = 4'h2;
  localparam logic [3:0] OFF_START_DET = 4'h3;
  localparam logic [3:0] OFF_RATED_START = 4'h4;
  localparam logic [3:0] OFF_MAX_TIME = 4'h5;
  localparam logic [3:0] OFF_AVERAGE = 4'h6;
  localparam logic [3:0] OFF_ELAPSED = 4'h7;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h9;

  // Field positions
  localparam int CTRL_DEP_BIT = 0;
  localparam int CTRL_EVT_BIT = 1;
  localparam int STAT_START_BIT = 2;
  localparam int STAT_TRIP_BIT = 3;
  localparam int STAT_BLOCK_BIT = 4;

  // Values after reset
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] NOMINAL_RST = 16'h0064;
  localparam logic [15:0] START_DET_RST = 16'h0258;
  localparam logic [15:0] RATED_START_RST = 16'h0258;
  localparam logic [15:0] MAX_TIME_RST = 16'h2710;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // Reported motor state codes
  localparam logic [1:0] MSTAT_STOPPED = 2'h0;
  localparam logic [1:0] MSTAT_STARTING = 2'h1;
  localparam logic [1:0] MSTAT_RUNNING = 2'h2;

  typedef enum logic [1:0] {
    MSU_STOPPED = 2'b00,
    MSU_WINDOW = 2'b01,
    MSU_STARTING = 2'b10,
    MSU_RUNNING = 2'b11
  } msu_state_t;

endpackage

// ===== design/msu_top.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
// Operation
// R01: Control bit chooses definite or current-dependent operate time.
// R02: Dependent time is max start time times (rated start / measured)^2.
// R03: Rated start current setting resets to six times nominal.
// R04: Timing starts on a rise from under 10% past start level in 200 ms.
// R05: Below 1.2 times nominal the stage releases start and timing. The code holds starting between 10% and 20% of nominal.
// R06: Stage acts only while the motor is in the starting state.
// R07: Average below one tenth of nominal reports the motor stopped.
// R08: Starting needs 500 ms stopped, then start level reached within 200 ms.
// R09: Starting holds until the running conditions are met.
// R10: Running from stopped or starting, limits 20% low and 120% high. From stopped the code checks only the 20% low limit.
// R11: Starting and running are exported as binary output signals.
// R12: Limit comparisons use the mean of the three phase magnitudes.
// R13: Soft start passes stopped to running with no start signal.
// R14: Start detection level resets to six times nominal.
// R15: Inputs are fundamental-frequency phase current magnitudes.
// R16: Block input suppresses start and trip; events only when enabled.
module msu_top #(
  parameter int unsigned MS_CYCLES = msu_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] phase_a_mag,
  input wire logic [15:0] phase_b_mag,
  input wire logic [15:0] phase_c_mag,
  input wire logic stage_block,
  output logic motor_starting,
  output logic motor_running,
  output logic stage_start,
  output logic stage_trip,
  output logic irq
);
  import msu_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // True when cur is below num/den of nom; cross-multiplied, no divider
  function automatic logic below_frac(
    input logic [15:0] cur,
    input logic [15:0] nom,
    input logic [3:0] num,
    input logic [3:0] den
  );
    return ({4'h0, cur} * {16'h0000, den}) < ({4'h0, nom} * {16'h0000, num});
  endfunction
  // Byte-lane merge of a 16-bit setting register
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    return {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
  endfunction
  // Saturating millisecond count
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [1:0] ctrl_reg;
  logic [15:0] nominal_reg, start_det_reg, rated_reg, max_time_reg;
  logic [3:0] irq_stat_reg, irq_mask_reg;
  logic irq_reg;
  logic blk_s1_reg, blk_s2_reg, blk_s3_reg, blocked_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] avg_reg;
  msu_state_t state_reg, state_next;
  logic [15:0] stop_ms_reg, win_ms_reg, elapsed_reg;
  logic tripped_reg;
  logic starting_reg, running_reg, start_reg, trip_reg;

  // ****************************************************************
  // Millisecond time base
  // ****************************************************************
  wire tick_wrap = (tick_cnt_reg == MS_CYCLES - 1);

  // The tick is one cycle late against the wrap; harmless at 1 ms
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? 32'h0000_0000 : tick_cnt_reg + 32'h1;
      tick_reg <= tick_wrap;
    end
  end

  // ****************************************************************
  // Block input synchroniser
  // ****************************************************************
  // Pin from outside; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      blk_s1_reg <= 1'b0;
      blk_s2_reg <= 1'b0;
      blk_s3_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end else begin
      blk_s1_reg <= stage_block;
      blk_s2_reg <= blk_s1_reg;
      blk_s3_reg <= blk_s2_reg;
      if (blk_s2_reg == blk_s3_reg) begin
        blocked_reg <= blk_s3_reg;
      end
    end
  end

  // ****************************************************************
  // Average current
  // ****************************************************************
  // Magnitudes are the fundamental component, same clock domain [R15]
  wire [17:0] phase_sum = {2'b00, phase_a_mag} + {2'b00, phase_b_mag}
                        + {2'b00, phase_c_mag};
  wire [17:0] phase_avg = phase_sum / 18'h00003; // Mean of three [R12]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avg_reg <= 16'h0000;
    end else begin
      avg_reg <= phase_avg[15:0];
    end
  end

  // ****************************************************************
  // Limit comparisons
  // ****************************************************************
  // The stop and running limits scale with the nominal current setting [R12]
  wire is_stopped = below_frac(avg_reg, nominal_reg, STOP_NUM,
                               STOP_DEN); // [R07]
  wire below_runlo = below_frac(avg_reg, nominal_reg, RUNLO_NUM,
                                RUNLO_DEN);
  wire below_runhi = below_frac(avg_reg, nominal_reg, RUNHI_NUM,
                                RUNHI_DEN);
  wire above_start = avg_reg > start_det_reg;
  wire stop_qualified = stop_ms_reg >= STOP_QUAL_MS; // [R08]
  wire win_over = win_ms_reg >= WINDOW_MS; // [R04]
  // Running band lies between the low and the high limit [R10]
  wire in_run_band = !below_runlo && below_runhi;

  // ****************************************************************
  // Motor state machine
  // ****************************************************************
  // Window state is reported as stopped; it only watches the rise
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MSU_STOPPED: begin
        if (!is_stopped && stop_qualified) begin
          state_next = MSU_WINDOW; // [R08]
        end else if (!is_stopped && !below_runlo) begin
          state_next = MSU_RUNNING; // [R10]
        end
      end
      MSU_WINDOW: begin
        if (above_start) begin
          state_next = MSU_STARTING; // [R04] [R08]
        end else if (is_stopped) begin
          state_next = MSU_STOPPED; // [R07]
        end else if (win_over && !below_runlo) begin
          state_next = MSU_RUNNING; // Soft start, no start signal [R13]
        end else if (win_over) begin
          state_next = MSU_STOPPED;
        end
      end
      MSU_STARTING: begin // Holds until running or stopped [R09]
        if (is_stopped) begin
          state_next = MSU_STOPPED; // [R07]
        end else if (in_run_band) begin
          state_next = MSU_RUNNING; // Release between 0.2 and 1.2 x nominal [R05]
        end
      end
      MSU_RUNNING: begin
        if (is_stopped) begin
          state_next = MSU_STOPPED; // [R07]
        end
      end
      default: state_next = MSU_STOPPED;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= MSU_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Sequence timers
  // ****************************************************************
  wire in_stopped = (state_reg == MSU_STOPPED);
  wire in_window = (state_reg == MSU_WINDOW);
  wire in_starting = (state_reg == MSU_STARTING);
  // Stop time only grows while the current stays under 10% [R08]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stop_ms_reg <= 16'h0000;
      win_ms_reg <= 16'h0000;
      elapsed_reg <= 16'h0000;
    end else begin
      if (!in_stopped || !is_stopped) begin
        stop_ms_reg <= 16'h0000;
      end else if (tick_reg) begin
        stop_ms_reg <= sat_inc(stop_ms_reg); // [R08]
      end
      if (!in_window) begin
        win_ms_reg <= 16'h0000;
      end else if (tick_reg) begin
        win_ms_reg <= sat_inc(win_ms_reg); // [R04]
      end
      if (!in_starting) begin
        elapsed_reg <= 16'h0000; // Timing drops on release [R05] [R06]
      end else if (tick_reg) begin
        elapsed_reg <= sat_inc(elapsed_reg); // [R04]
      end
    end
  end

  // ****************************************************************
  // Operate time
  // ****************************************************************
  // Dependent time compared as elapsed*I^2 >= Tmax*Ist^2, which
  // avoids a divider at the cost of four wide multipliers [R02]
  wire [47:0] dep_lhs = {32'h0000_0000, elapsed_reg}
    * {32'h0000_0000, avg_reg} * {32'h0000_0000, avg_reg};
  wire [47:0] dep_rhs = {32'h0000_0000, max_time_reg}
    * {32'h0000_0000, rated_reg} * {32'h0000_0000, rated_reg};
  wire dep_done = dep_lhs >= dep_rhs; // [R02]
  wire def_done = elapsed_reg >= max_time_reg;
  wire op_done = ctrl_reg[CTRL_DEP_BIT] ? dep_done : def_done; // [R01]
  // Trip holds until the stage releases
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tripped_reg <= 1'b0;
    end else if (state_next != MSU_STARTING) begin
      tripped_reg <= 1'b0; // [R05] [R06]
    end else if (in_starting && op_done) begin
      tripped_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Stage outputs
  // ****************************************************************
  wire start_d = in_starting && !blocked_reg; // [R06] [R16]
  wire trip_d = tripped_reg && !blocked_reg; // [R16]
  // Registered so every pin comes straight from a flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      starting_reg <= 1'b0;
      running_reg <= 1'b0;
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
    end else begin
      starting_reg <= in_starting; // [R11]
      running_reg <= (state_reg == MSU_RUNNING); // [R11]
      start_reg <= start_d;
      trip_reg <= trip_d;
    end
  end

  assign motor_starting = starting_reg;
  assign motor_running = running_reg;
  assign stage_start = start_reg;
  assign stage_trip = trip_reg;

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  // Bits: 0 start on, 1 start off, 2 trip on, 3 trip off
  wire [3:0] evt_raw = {!trip_d && trip_reg, trip_d && !trip_reg,
                        !start_d && start_reg, start_d && !start_reg};
  wire [3:0] evt = evt_raw & {4{ctrl_reg[CTRL_EVT_BIT]}}; // [R16]

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  wire bus_req = avs_read || avs_write;
  wire wr_acc = avs_write && !wait_reg;
  wire we_ctrl = wr_acc && (avs_address == OFF_CTRL);
  wire we_nom = wr_acc && (avs_address == OFF_NOMINAL);
  wire we_sdet = wr_acc && (avs_address == OFF_START_DET);
  wire we_rated = wr_acc && (avs_address == OFF_RATED_START);
  wire we_maxt = wr_acc && (avs_address == OFF_MAX_TIME);
  wire we_istat = wr_acc && (avs_address == OFF_IRQ_STAT);
  wire we_imask = wr_acc && (avs_address == OFF_IRQ_MASK);
  wire [3:0] w1c = (we_istat && avs_byteenable[0]) ?
                   avs_writedata[3:0] : 4'h0;
  // A new event wins over a clear in the same cycle
  wire [3:0] irq_stat_next = (irq_stat_reg & ~w1c) | evt;
  wire [4:0] status_bits = {blocked_reg, trip_reg, start_reg,
                            in_starting ? MSTAT_STARTING :
                            (state_reg == MSU_RUNNING) ? MSTAT_RUNNING :
                            MSTAT_STOPPED}; // [R07]

  // Read mux; unmapped addresses read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == OFF_CTRL) begin
      rd_mux = {30'h0, ctrl_reg};
    end else if (avs_address == OFF_STATUS) begin
      rd_mux = {27'h0, status_bits};
    end else if (avs_address == OFF_NOMINAL) begin
      rd_mux = {16'h0, nominal_reg};
    end else if (avs_address == OFF_START_DET) begin
      rd_mux = {16'h0, start_det_reg};
    end else if (avs_address == OFF_RATED_START) begin
      rd_mux = {16'h0, rated_reg};
    end else if (avs_address == OFF_MAX_TIME) begin
      rd_mux = {16'h0, max_time_reg};
    end else if (avs_address == OFF_AVERAGE) begin
      rd_mux = {16'h0, avg_reg};
    end else if (avs_address == OFF_ELAPSED) begin
      rd_mux = {16'h0, elapsed_reg};
    end else if (avs_address == OFF_IRQ_STAT) begin
      rd_mux = {28'h0, irq_stat_reg};
    end else if (avs_address == OFF_IRQ_MASK) begin
      rd_mux = {28'h0, irq_mask_reg};
    end
  end

  // Waitrequest drops for one cycle, so every access takes two
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (avs_read && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  // Settings; start levels reset to six times nominal [R03] [R14]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      nominal_reg <= NOMINAL_RST;
      start_det_reg <= START_DET_RST; // [R14]
      rated_reg <= RATED_START_RST; // [R03]
      max_time_reg <= MAX_TIME_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else begin
      if (we_ctrl && avs_byteenable[0]) begin
        ctrl_reg <= avs_writedata[1:0]; // Mode select [R01]
      end
      if (we_nom) begin
        nominal_reg <= merge16(nominal_reg, avs_writedata, avs_byteenable);
      end
      if (we_sdet) begin
        start_det_reg <= merge16(start_det_reg, avs_writedata, avs_byteenable);
      end
      if (we_rated) begin
        rated_reg <= merge16(rated_reg, avs_writedata, avs_byteenable);
      end
      if (we_maxt) begin
        max_time_reg <= merge16(max_time_reg, avs_writedata, avs_byteenable);
      end
      if (we_imask && avs_byteenable[0]) begin
        irq_mask_reg <= avs_writedata[3:0];
      end
    end
  end

  // Sticky status and level interrupt, one cycle behind the bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next; // [R16]
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

endmodule

// ===== verif/msu_monitor.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checker of the start-up supervision stage
// ****************************************************************
module msu_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] phase_a_mag,
  input wire logic [15:0] phase_b_mag,
  input wire logic [15:0] phase_c_mag,
  input wire logic stage_block,
  input wire logic motor_starting,
  input wire logic motor_running,
  input wire logic stage_start,
  input wire logic stage_trip,
  input wire logic irq
);
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Steps of a bus access and of a held block request
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_block_held;
    stage_block [*6];
  endsequence

  a_req_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Read data must not drift while no read is being latched
  a_rdata_hold: assert property (!$past(avs_read && avs_waitrequest)
    |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> avs_waitrequest
    && !motor_starting && !motor_running && !stage_start && !stage_trip)
    else $error("outputs not idle after reset");
  a_start_gate: assert property (stage_start |-> motor_starting)
    else $error("start without starting state");
  a_trip_gate: assert property (stage_trip |-> stage_start)
    else $error("trip without start");
  a_state_excl: assert property (!(motor_starting && motor_running))
    else $error("starting and running together");
  // Block passes a short synchroniser, so allow it a few cycles
  a_block_quiet: assert property (s_block_held
    |-> !stage_start && !stage_trip)
    else $error("start or trip while blocked");
  // Running never falls straight into starting; it must stop first
  a_run_exit: assert property ($fell(motor_running) |-> !motor_starting
    && !stage_trip)
    else $error("running left for starting");
endmodule

// ===== verif/msu_meas_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Three-phase fundamental magnitude source
// ****************************************************************
module msu_meas_model (
  input wire logic ref_clk,
  input wire logic [15:0] level,
  output logic [15:0] phase_a,
  output logic [15:0] phase_b,
  output logic [15:0] phase_c
);
  logic [15:0] skew;

  // Symmetric unbalance keeps the mean exact, so a peak-based stage fails
  assign skew = level >> 3;

  // A fresh magnitude set every clock, as a DFT stage would give
  always_ff @(posedge ref_clk) begin
    phase_a <= level + skew;
    phase_b <= level;
    phase_c <= level - skew;
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import msu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] phase_a_mag, phase_b_mag, phase_c_mag;
  logic [15:0] level = 16'h0;
  logic stage_block = 1'b0;
  logic motor_starting, motor_running, stage_start, stage_trip, irq;
  logic [31:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  // ****************************************************************
  // Clock, design and current source
  // ****************************************************************
  always #5 ref_clk = ~ref_clk;

  msu_top #(.MS_CYCLES(10)) u_msu_top (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .phase_a_mag(phase_a_mag), .phase_b_mag(phase_b_mag),
    .phase_c_mag(phase_c_mag), .stage_block(stage_block),
    .motor_starting(motor_starting), .motor_running(motor_running),
    .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));

  msu_meas_model u_msu_meas_model (.ref_clk(ref_clk), .level(level),
    .phase_a(phase_a_mag), .phase_b(phase_b_mag), .phase_c(phase_c_mag));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) bad_count++;
  endtask

  task wait_ms(input int n);
    repeat (n * 10) @(posedge ref_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset_vals;
    bus(0, OFF_CTRL, 0, rd);
    chk_val(rd, 32'h0);
    bus(0, OFF_START_DET, 0, rd);
    chk_val(rd, 32'h258);
    bus(0, OFF_RATED_START, 0, rd);
    chk_val(rd, 32'h258);
    bus(0, 4'hf, 0, rd);
    chk_val(rd, 32'h0);
    bus(0, OFF_STATUS, 0, rd);
    chk_val(rd, 32'h0);
  endtask

  // Direct start, definite trip, block, then release into running
  task t_dol_start;
    bus(1, OFF_MAX_TIME, 32'h14, rd);
    bus(1, OFF_CTRL, 32'h2, rd);
    bus(1, OFF_IRQ_MASK, 32'h4, rd);
    wait_ms(510);
    level <= 16'h2bc;
    wait_ms(5);
    chk_bit(motor_starting, 1'b1);
    chk_bit(stage_start, 1'b1);
    chk_bit(stage_trip, 1'b0);
    bus(0, OFF_STATUS, 0, rd);
    chk_val(rd, 32'h5);
    bus(0, OFF_AVERAGE, 0, rd);
    chk_val(rd, 32'h2bc);
    wait_ms(20);
    chk_bit(stage_trip, 1'b1);
    chk_bit(irq, 1'b1);
    stage_block <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk_bit(stage_start, 1'b0);
    chk_bit(stage_trip, 1'b0);
    chk_bit(motor_starting, 1'b1);
    stage_block <= 1'b0;
    level <= 16'h64;
    wait_ms(2);
    chk_bit(motor_running, 1'b1);
    chk_bit(stage_start, 1'b0);
    chk_bit(stage_trip, 1'b0);
    bus(0, OFF_IRQ_STAT, 0, rd);
    chk_val(rd, 32'hf);
    bus(1, OFF_IRQ_STAT, 32'hf, rd);
    bus(0, OFF_IRQ_STAT, 0, rd);
    chk_val(rd, 32'h0);
    chk_bit(irq, 1'b0);
  endtask

  // Low-current start goes to running with no start signal
  task t_soft_start;
    level <= 16'h0;
    wait_ms(2);
    chk_bit(motor_running, 1'b0);
    wait_ms(510);
    level <= 16'h32;
    wait_ms(100);
    chk_bit(motor_starting, 1'b0);
    chk_bit(stage_start, 1'b0);
    wait_ms(110);
    chk_bit(motor_running, 1'b1);
    chk_bit(stage_start, 1'b0);
  endtask

  // Dependent time: 40 ms * (600 / 1200)^2 gives 10 ms
  task t_dependent;
    bus(1, OFF_CTRL, 32'h3, rd);
    bus(1, OFF_MAX_TIME, 32'h28, rd);
    level <= 16'h0;
    wait_ms(510);
    level <= 16'h4b0;
    wait_ms(7);
    chk_bit(motor_starting, 1'b1);
    chk_bit(stage_trip, 1'b0);
    wait_ms(6);
    chk_bit(stage_trip, 1'b1);
    level <= 16'h0;
    wait_ms(2);
    chk_bit(motor_starting, 1'b0);
    chk_bit(stage_trip, 1'b0);
  endtask

  // Main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_vals;
    t_dol_start;
    t_soft_start;
    t_dependent;
    test_done;
  end

  // Hang guard; the run needs about 18000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      test_done;
    end
  end
endmodule

bind msu_top msu_monitor u_msu_monitor (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .phase_a_mag(phase_a_mag), .phase_b_mag(phase_b_mag),
  .phase_c_mag(phase_c_mag), .stage_block(stage_block),
  .motor_starting(motor_starting), .motor_running(motor_running),
  .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));
